//--- shared/tbc_pkg.sv
// Constants for the basic up-counting timer
// Contract
// - 16-bit up counter with auto reload
// - Prescaler divides by programmed value plus one
// - New prescale takes effect at update event
// - Reload preload copied immediately or at update
// - Overflow or software force makes update event
// - Counter runs only while enable set
// - Count zero to reload value, then wrap
// - Source select hides flag on forced update
// - Update sets flag, reloads prescale and reload
// - Update disable suppresses update events
// - Update clears counter and prescaler count
// - Prescaler clocked from internal clock when enabled
// - Debug halt may freeze the counter
// - Half-word and word bus accesses accepted
// - Count registers readable and writable while running
// - Update event sole interrupt and DMA source
// - Preload disabled means reload acts directly
package tbc_pkg;
	// ----------------------------------------
	// Register offsets
	// ----------------------------------------
	localparam logic [7:0] OFF_CTRL = 8'h00;
	localparam logic [7:0] OFF_INTEN = 8'h0C;
	localparam logic [7:0] OFF_STATUS = 8'h10;
	localparam logic [7:0] OFF_EVENT = 8'h14;
	localparam logic [7:0] OFF_COUNT = 8'h24;
	localparam logic [7:0] OFF_PRESCALE = 8'h28;
	localparam logic [7:0] OFF_RELOAD = 8'h2C;
	localparam logic [7:0] OFF_DEBUG = 8'h30;
	// ----------------------------------------
	// Field positions
	// ----------------------------------------
	localparam int CTRL_RUN = 0;
	localparam int CTRL_UPD_DIS = 1;
	localparam int CTRL_SRC_SEL = 2;
	localparam int CTRL_ONE_PULSE = 3;
	localparam int CTRL_PRELOAD = 7;
	localparam int INTEN_IRQ = 0;
	localparam int INTEN_DMA = 8;
	localparam int STATUS_FLAG = 0;
	localparam int EVENT_FORCE = 0;
	localparam int DEBUG_FREEZE = 0;
	// ----------------------------------------
	// Reset values and bus codes
	// ----------------------------------------
	localparam logic [15:0] RST_RELOAD = 16'hFFFF;
	localparam logic [15:0] RST_ZERO = 16'h0000;
	localparam logic [2:0] HSIZE_BYTE = 3'h0;
	localparam logic [2:0] HSIZE_HALF = 3'h1;
	localparam logic [1:0] HRESP_OKAY = 2'h0;
	localparam int CLK_MHZ = 200;
endpackage

//--- core/tbc_prescaler.sv
// Prescaler counter producing one tick per divided period
`timescale 1ns/1ps
module tbc_prescaler (
	input wire logic clk,
	input wire logic resetn,
	input wire logic run,
	input wire logic clear,
	input wire logic [15:0] divider,
	output logic tick
);
	typedef struct packed
	{
		logic [15:0] count;
	} tbc_psc_state_t;

	tbc_psc_state_t q;
	tbc_psc_state_t d;

	// Divide by divider plus one: tick when count reaches divider
	assign tick = run && (q.count == divider);

	always_comb
	begin
		d = q;
		if (clear)
		begin
			d.count = 16'h0000;
		end
		else if (tick)
		begin
			d.count = 16'h0000;
		end
		else if (run)
		begin
			d.count = q.count + 16'h0001;
		end
	end

	always_ff @(posedge clk)
	begin
		if (!resetn)
		begin
			q <= '0;
		end
		else
		begin
			q <= d;
		end
	end

	a_tick_spacing: assert property (@(posedge clk) disable iff (!resetn)
		(tick && !clear && divider != 16'h0000) |=> !tick)
		else $error("prescaler ticked twice in a row with divider above zero");
endmodule

//--- core/tbc_timer.sv
// Basic 16-bit up-counting timer with AHB-Lite register slave
//
// Added by the designer: the register offsets and the AHB-Lite slave port.
`timescale 1ns/1ps
module tbc_timer (
	input wire logic CLK,
	input wire logic RESETN,
	input wire logic HSEL,
	input wire logic [31:0] HADDR,
	input wire logic [1:0] HTRANS,
	input wire logic HWRITE,
	input wire logic [2:0] HSIZE,
	input wire logic [31:0] HWDATA,
	input wire logic HREADY,
	output logic HREADYOUT,
	output logic [31:0] HRDATA,
	output logic HRESP,
	input wire logic DEBUG_HALT,
	output logic IRQ,
	output logic DMA_REQ
);
	// ----------------------------------------
	// State
	// ----------------------------------------
	typedef struct packed
	{
		logic wr_pend;
		logic [7:0] wr_addr;
		logic [3:0] wr_be;
		logic counter_run_enable;
		logic update_disable;
		logic update_source_select;
		logic one_pulse;
		logic reload_preload_enable;
		logic irq_enable;
		logic dma_enable;
		logic update_flag;
		logic debug_halt_freeze;
		logic [1:0] halt_sync;
		logic [15:0] count_value;
		logic [15:0] prescale_value;
		logic [15:0] prescale_shadow;
		logic [15:0] reload_value;
		logic [15:0] reload_shadow;
		logic [31:0] rdata;
		logic irq;
		logic dma;
	} tbc_state_t;

	tbc_state_t q;
	tbc_state_t d;

	logic tick;
	logic run_eff;
	logic [15:0] reload_active;
	logic overflow;
	logic force_update_event;
	logic update_event;
	logic bus_access;
	logic wr_ctrl;
	logic wr_inten;
	logic wr_status;
	logic wr_event;
	logic wr_count;
	logic wr_prescale;
	logic wr_reload;
	logic wr_debug;

	// ----------------------------------------
	// Helpers
	// ----------------------------------------
	function automatic logic [3:0] lanes_of(input logic [2:0] size, input logic [1:0] addr);
		logic [3:0] be;
		be = 4'hF;
		case (size)
			tbc_pkg::HSIZE_BYTE: be = 4'h1 << addr;
			tbc_pkg::HSIZE_HALF: be = addr[1] ? 4'hC : 4'h3;
			default: be = 4'hF;
		endcase
		return be;
	endfunction

	function automatic logic [15:0] merge16(input logic [15:0] old, input logic [3:0] be,
		input logic [31:0] wdata);
		logic [15:0] r;
		r = old;
		if (be[0])
		begin
			r[7:0] = wdata[7:0];
		end
		if (be[1])
		begin
			r[15:8] = wdata[15:8];
		end
		return r;
	endfunction

	function automatic logic [31:0] read_mux(input tbc_state_t s, input logic [7:0] addr);
		logic [31:0] r;
		r = 32'h00000000;
		case (addr)
			tbc_pkg::OFF_CTRL:
			begin
				r[tbc_pkg::CTRL_RUN] = s.counter_run_enable;
				r[tbc_pkg::CTRL_UPD_DIS] = s.update_disable;
				r[tbc_pkg::CTRL_SRC_SEL] = s.update_source_select;
				r[tbc_pkg::CTRL_ONE_PULSE] = s.one_pulse;
				r[tbc_pkg::CTRL_PRELOAD] = s.reload_preload_enable;
			end
			tbc_pkg::OFF_INTEN:
			begin
				r[tbc_pkg::INTEN_IRQ] = s.irq_enable;
				r[tbc_pkg::INTEN_DMA] = s.dma_enable;
			end
			tbc_pkg::OFF_STATUS: r[tbc_pkg::STATUS_FLAG] = s.update_flag;
			tbc_pkg::OFF_COUNT: r[15:0] = s.count_value;
			tbc_pkg::OFF_PRESCALE: r[15:0] = s.prescale_value;
			tbc_pkg::OFF_RELOAD: r[15:0] = s.reload_value;
			tbc_pkg::OFF_DEBUG: r[tbc_pkg::DEBUG_FREEZE] = s.debug_halt_freeze;
			default: r = 32'h00000000;
		endcase
		return r;
	endfunction

	// ----------------------------------------
	// Time base
	// ----------------------------------------
	// Halt only freezes when software asked for it
	assign run_eff = q.counter_run_enable && !(q.debug_halt_freeze && q.halt_sync[1]);

	tbc_prescaler u_prescaler (
		.clk(CLK),
		.resetn(RESETN),
		.run(run_eff),
		.clear(update_event),
		.divider(q.prescale_shadow),
		.tick(tick)
	);

	// Without preload the written value is compared directly
	assign reload_active = q.reload_preload_enable ? q.reload_shadow : q.reload_value;
	assign overflow = tick && (q.count_value == reload_active);

	// ----------------------------------------
	// Write decode, data phase
	// ----------------------------------------
	assign bus_access = HSEL && HTRANS[1] && HREADY;
	assign wr_ctrl = q.wr_pend && (q.wr_addr == tbc_pkg::OFF_CTRL);
	assign wr_inten = q.wr_pend && (q.wr_addr == tbc_pkg::OFF_INTEN);
	assign wr_status = q.wr_pend && (q.wr_addr == tbc_pkg::OFF_STATUS);
	assign wr_event = q.wr_pend && (q.wr_addr == tbc_pkg::OFF_EVENT);
	assign wr_count = q.wr_pend && (q.wr_addr == tbc_pkg::OFF_COUNT);
	assign wr_prescale = q.wr_pend && (q.wr_addr == tbc_pkg::OFF_PRESCALE);
	assign wr_reload = q.wr_pend && (q.wr_addr == tbc_pkg::OFF_RELOAD);
	assign wr_debug = q.wr_pend && (q.wr_addr == tbc_pkg::OFF_DEBUG);

	// Forced event ignored while updates are disabled
	assign force_update_event = wr_event && q.wr_be[0] && HWDATA[tbc_pkg::EVENT_FORCE]
		&& !q.update_disable;
	assign update_event = (overflow && !q.update_disable) || force_update_event;

	// ----------------------------------------
	// Next state
	// ----------------------------------------
	always_comb
	begin
		d = q;
		d.halt_sync = {q.halt_sync[0], DEBUG_HALT};

		// Address phase capture; zero wait states
		d.wr_pend = bus_access && HWRITE;
		if (bus_access)
		begin
			d.wr_addr = {HADDR[7:2], 2'b00};
			d.wr_be = lanes_of(HSIZE, HADDR[1:0]);
		end
		if (bus_access && !HWRITE)
		begin
			d.rdata = read_mux(q, {HADDR[7:2], 2'b00});
		end

		// Control writes take effect on the next edge, so counting starts a cycle later
		if (wr_ctrl && q.wr_be[0])
		begin
			d.counter_run_enable = HWDATA[tbc_pkg::CTRL_RUN];
			d.update_disable = HWDATA[tbc_pkg::CTRL_UPD_DIS];
			d.update_source_select = HWDATA[tbc_pkg::CTRL_SRC_SEL];
			d.one_pulse = HWDATA[tbc_pkg::CTRL_ONE_PULSE];
			d.reload_preload_enable = HWDATA[tbc_pkg::CTRL_PRELOAD];
		end
		if (wr_inten && q.wr_be[0])
		begin
			d.irq_enable = HWDATA[tbc_pkg::INTEN_IRQ];
		end
		if (wr_inten && q.wr_be[1])
		begin
			d.dma_enable = HWDATA[tbc_pkg::INTEN_DMA];
		end
		if (wr_debug && q.wr_be[0])
		begin
			d.debug_halt_freeze = HWDATA[tbc_pkg::DEBUG_FREEZE];
		end
		if (wr_prescale)
		begin
			d.prescale_value = merge16(q.prescale_value, q.wr_be, HWDATA);
		end
		if (wr_reload)
		begin
			d.reload_value = merge16(q.reload_value, q.wr_be, HWDATA);
		end

		// Counter: wrap on overflow even when updates are disabled
		if (update_event || overflow)
		begin
			d.count_value = 16'h0000;
		end
		else if (tick)
		begin
			d.count_value = q.count_value + 16'h0001;
		end
		if (wr_count)
		begin
			d.count_value = merge16(q.count_value, q.wr_be, HWDATA);
		end

		// Shadow registers
		if (update_event)
		begin
			d.prescale_shadow = q.prescale_value;
		end
		if (!q.reload_preload_enable)
		begin
			d.reload_shadow = q.reload_value;
		end
		else if (update_event)
		begin
			d.reload_shadow = q.reload_value;
		end
		if (update_event && q.one_pulse)
		begin
			d.counter_run_enable = 1'b0;
		end

		// Flag: set wins over a write-one clear in the same cycle
		if (wr_status && q.wr_be[0] && HWDATA[tbc_pkg::STATUS_FLAG])
		begin
			d.update_flag = 1'b0;
		end
		if ((overflow && !q.update_disable) || (force_update_event && !q.update_source_select))
		begin
			d.update_flag = 1'b1;
		end

		// Update flag is the only request source
		d.irq = d.update_flag && d.irq_enable;
		d.dma = d.update_flag && d.dma_enable;
	end

	always_ff @(posedge CLK)
	begin
		if (!RESETN)
		begin
			q <= '0;
			q.reload_value <= tbc_pkg::RST_RELOAD;
			q.reload_shadow <= tbc_pkg::RST_RELOAD;
			q.prescale_shadow <= tbc_pkg::RST_ZERO;
		end
		else
		begin
			q <= d;
		end
	end

	// ----------------------------------------
	// Outputs
	// ----------------------------------------
	assign HREADYOUT = 1'b1;
	assign HRESP = tbc_pkg::HRESP_OKAY[0];
	assign HRDATA = q.rdata;
	assign IRQ = q.irq;
	assign DMA_REQ = q.dma;

	// ----------------------------------------
	// Assertions
	// ----------------------------------------
	default clocking cb @(posedge CLK);
	endclocking
	default disable iff (!RESETN);

	a_count_step: assert property ((tick && !overflow && !wr_count && !update_event)
		|=> q.count_value == $past(q.count_value) + 16'h0001)
		else $error("counter did not step by one on a tick");
	a_count_wrap: assert property ((overflow && !wr_count) |=> q.count_value == 16'h0000)
		else $error("counter did not return to zero after reaching reload");
	a_flag_on_ovf: assert property ((overflow && !q.update_disable) |=> q.update_flag)
		else $error("overflow did not set the update flag");
	a_quiet_force: assert property ((force_update_event && q.update_source_select && !overflow
		&& !q.update_flag) |=> !q.update_flag && !IRQ)
		else $error("forced update with source select raised the flag");
	a_disable_hold: assert property (q.update_disable |=> $stable(q.prescale_shadow))
		else $error("prescale shadow changed while updates disabled");
	a_direct_reload: assert property (!q.reload_preload_enable
		|=> q.reload_shadow == $past(q.reload_value))
		else $error("reload shadow did not follow preload when buffering off");
	a_psc_reload: assert property (update_event |=> q.prescale_shadow == $past(q.prescale_value))
		else $error("prescale shadow not reloaded at update event");
	a_psc_restart: assert property ((update_event && q.prescale_value != 16'h0000)
		|=> !tick)
		else $error("prescaler count not restarted by update event");
	a_stop_gate: assert property ((!run_eff && !wr_count && !update_event)
		|=> $stable(q.count_value))
		else $error("counter moved while stopped or frozen");
	a_freeze_hold: assert property ((q.counter_run_enable && q.debug_halt_freeze
		&& q.halt_sync[1] && !wr_count && !update_event) |=> $stable(q.count_value))
		else $error("counter moved during frozen debug halt");
	a_irq_follow: assert property ((q.update_flag && q.irq_enable) |=> IRQ || $fell(q.update_flag)
		|| $fell(q.irq_enable))
		else $error("interrupt missing while flag and enable set");
	a_dma_source: assert property ($rose(DMA_REQ) |-> q.update_flag && q.dma_enable)
		else $error("DMA request rose without an update flag");
	a_dma_follow: assert property ((q.update_flag && q.dma_enable)
		|=> DMA_REQ || $fell(q.update_flag) || $fell(q.dma_enable))
		else $error("DMA request missing while flag and enable set");
	a_update_clear: assert property ((update_event && !wr_count)
		|=> q.count_value == 16'h0000)
		else $error("update event did not clear the counter");
	a_reload_held: assert property ((q.reload_preload_enable && !update_event)
		|=> $stable(q.reload_shadow))
		else $error("buffered reload shadow changed without an update event");
	a_reload_update: assert property ((q.reload_preload_enable && update_event)
		|=> q.reload_shadow == $past(q.reload_value))
		else $error("buffered reload shadow not loaded at update event");
	a_disabled_quiet: assert property ((q.update_disable && !q.update_flag)
		|=> !q.update_flag)
		else $error("update flag set while updates disabled");

	// Software clear racing a hardware set must never lose the event
	a_set_wins: assert property ((wr_status && q.wr_be[0] && HWDATA[tbc_pkg::STATUS_FLAG]
		&& overflow && !q.update_disable) |=> q.update_flag)
		else $error("flag clear overrode a same-cycle update");
	a_flag_clear: assert property ((wr_status && q.wr_be[0] && HWDATA[tbc_pkg::STATUS_FLAG]
		&& !overflow && !force_update_event) |=> !q.update_flag)
		else $error("write of one did not clear the update flag");
	a_one_pulse_stop: assert property ((update_event && q.one_pulse && !wr_ctrl)
		|=> !q.counter_run_enable)
		else $error("one-pulse mode kept running after an update event");
endmodule

//--- verification/tbc_timer_tb_top.sv
// Self-checking testbench for the basic up-counting timer
`timescale 1ns/1ps
module tbc_timer_tb_top;
	logic CLK = 1'b0;
	logic RESETN = 1'b0;
	logic HSEL = 1'b0;
	logic [31:0] HADDR = 32'h0;
	logic [1:0] HTRANS = 2'h0;
	logic HWRITE = 1'b0;
	logic [2:0] HSIZE = 3'h2;
	logic [31:0] HWDATA = 32'h0;
	logic DEBUG_HALT = 1'b0;
	wire logic HREADYOUT;
	wire logic [31:0] HRDATA;
	wire logic HRESP;
	wire logic IRQ;
	wire logic DMA_REQ;
	int errors = 0;
	int checked = 0;
	int cyc = 0;
	int last = 0;
	int seed = 32'hBD30;
	int exp_q[$];
	tbc_timer tbc_timer_i (.CLK(CLK), .RESETN(RESETN), .HSEL(HSEL), .HADDR(HADDR),
		.HTRANS(HTRANS), .HWRITE(HWRITE), .HSIZE(HSIZE), .HWDATA(HWDATA), .HREADY(HREADYOUT),
		.HREADYOUT(HREADYOUT), .HRDATA(HRDATA), .HRESP(HRESP), .DEBUG_HALT(DEBUG_HALT),
		.IRQ(IRQ), .DMA_REQ(DMA_REQ));
	initial
	begin
		forever #2.5 CLK = ~CLK;
	end
	always @(posedge CLK) cyc <= cyc + 1;
	// ----------------------------------------
	// Checking and bus tasks
	// ----------------------------------------
	task automatic summarize();
		$display("errors=%0d checked=%0d", errors, checked);
		if (errors == 0 && checked > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
		checked++;
		if (got !== exp)
		begin
			errors++;
			$display("[FAIL] %0t %s: got %h expected %h", $time, msg, got, exp);
		end
	endtask
	// Master holds each phase until hready is seen high
	task automatic bus(input logic w, input logic [7:0] a, input logic [2:0] sz,
		input logic [31:0] wd, output logic [31:0] rd);
		@(posedge CLK);
		HSEL <= 1'b1;
		HTRANS <= 2'h2;
		HADDR <= {24'h0, a};
		HWRITE <= w;
		HSIZE <= sz;
		do @(posedge CLK); while (HREADYOUT !== 1'b1);
		HTRANS <= 2'h0;
		HWDATA <= wd;
		do @(posedge CLK); while (HREADYOUT !== 1'b1);
		rd = HRDATA;
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [2:0] sz = 3'h2);
		logic [31:0] dmy;
		bus(1'b1, a, sz, d, dmy);
	endtask
	task automatic rdc(input logic [7:0] a, input logic [31:0] exp, input string msg);
		logic [31:0] v;
		bus(1'b0, a, 3'h2, 32'h0, v);
		chk(v, exp, msg);
		chk({31'h0, HRESP}, 32'h0, "response");
		chk({31'h0, HREADYOUT}, 32'h1, "ready");
	endtask
	// Interrupt edge, then clear the sticky flag so the next one shows
	task automatic rise(output int t);
		do @(negedge CLK); while (IRQ !== 1'b1);
		t = cyc;
		chk({31'h0, DMA_REQ}, 32'h1, "dma request with flag");
		wr(tbc_pkg::OFF_STATUS, 32'h1);
	endtask
	task automatic per(input string msg);
		int t;
		rise(t);
		chk(t - last, exp_q.pop_front(), msg);
		last = t;
	endtask
	// ----------------------------------------
	// Main sequence
	// ----------------------------------------
	initial
	begin
		int p;
		int p2;
		int a;
		int a2;
		int a3;
		logic [31:0] c1;
		logic [31:0] c2;
		p = 1 + ($unsigned($random(seed)) % 3);
		p2 = (p % 3) + 1;
		a = 4 + ($unsigned($random(seed)) % 8);
		a2 = a + 4;
		a3 = a2 + 3;
		repeat (16) @(posedge CLK);
		RESETN <= 1'b1;
		@(posedge CLK);
		rdc(tbc_pkg::OFF_RELOAD, 32'hFFFF, "reload reset");
		rdc(tbc_pkg::OFF_COUNT, 32'h0, "count reset");
		rdc(tbc_pkg::OFF_CTRL, 32'h0, "control reset");
		rdc(8'h40, 32'h0, "unmapped read");
		wr(tbc_pkg::OFF_PRESCALE, p);
		wr(tbc_pkg::OFF_RELOAD, a);
		wr(tbc_pkg::OFF_EVENT, 32'h1);
		rdc(tbc_pkg::OFF_STATUS, 32'h1, "forced update flag");
		wr(tbc_pkg::OFF_STATUS, 32'h1);
		rdc(tbc_pkg::OFF_STATUS, 32'h0, "flag cleared");
		wr(tbc_pkg::OFF_INTEN, 32'h101);
		wr(tbc_pkg::OFF_CTRL, 32'h1);
		rise(last);
		exp_q = {(a + 1) * (p + 1), (a + 1) * (p + 1), (a + 1) * (p2 + 1)};
		per("period");
		wr(tbc_pkg::OFF_PRESCALE, p2);
		per("old prescale until update");
		per("new prescale after update");
		wr(tbc_pkg::OFF_CTRL, 32'h81);
		wr(tbc_pkg::OFF_RELOAD, a2);
		exp_q = {(a + 1) * (p2 + 1), (a2 + 1) * (p2 + 1), (a3 + 1) * (p2 + 1)};
		per("buffered reload waits");
		per("buffered reload applied");
		wr(tbc_pkg::OFF_CTRL, 32'h1);
		wr(tbc_pkg::OFF_RELOAD, a3);
		per("direct reload");
		wr(tbc_pkg::OFF_CTRL, 32'h3);
		repeat (3 * (a3 + 1) * (p2 + 1)) @(posedge CLK);
		chk({31'h0, IRQ}, 32'h0, "no event when disabled");
		wr(tbc_pkg::OFF_EVENT, 32'h1);
		rdc(tbc_pkg::OFF_STATUS, 32'h0, "force ignored when disabled");
		wr(tbc_pkg::OFF_CTRL, 32'h4);
		wr(tbc_pkg::OFF_COUNT, 32'h7);
		rdc(tbc_pkg::OFF_COUNT, 32'h7, "count write");
		wr(tbc_pkg::OFF_EVENT, 32'h1);
		rdc(tbc_pkg::OFF_COUNT, 32'h0, "force clears count");
		rdc(tbc_pkg::OFF_STATUS, 32'h0, "quiet forced update");
		chk({31'h0, IRQ}, 32'h0, "no interrupt");
		wr(tbc_pkg::OFF_DEBUG, 32'h1);
		wr(tbc_pkg::OFF_CTRL, 32'h1);
		DEBUG_HALT <= 1'b1;
		repeat (4) @(posedge CLK);
		bus(1'b0, tbc_pkg::OFF_COUNT, 3'h2, 32'h0, c1);
		repeat (20) @(posedge CLK);
		rdc(tbc_pkg::OFF_COUNT, c1, "frozen in debug");
		DEBUG_HALT <= 1'b0;
		repeat (12) @(posedge CLK);
		bus(1'b0, tbc_pkg::OFF_COUNT, 3'h2, 32'h0, c2);
		chk({31'h0, c2 === c1}, 32'h0, "runs after debug");
		wr(8'h2A, 32'h0009_0000, tbc_pkg::HSIZE_HALF);
		rdc(tbc_pkg::OFF_PRESCALE, p2, "upper half ignored");
		wr(tbc_pkg::OFF_PRESCALE, 32'h2, tbc_pkg::HSIZE_HALF);
		rdc(tbc_pkg::OFF_PRESCALE, 32'h2, "half-word write");
		// Stop first so no overflow can slip in between clear and start
		wr(tbc_pkg::OFF_CTRL, 32'h0);
		wr(tbc_pkg::OFF_STATUS, 32'h1);
		wr(tbc_pkg::OFF_INTEN, 32'h1);
		wr(tbc_pkg::OFF_CTRL, 32'h9);
		do @(negedge CLK); while (IRQ !== 1'b1);
		chk({31'h0, DMA_REQ}, 32'h0, "no dma request when disabled");
		rdc(tbc_pkg::OFF_CTRL, 32'h8, "one pulse stops run");
		rdc(tbc_pkg::OFF_COUNT, 32'h0, "count cleared at update");
		wr(tbc_pkg::OFF_STATUS, 32'h1);
		rdc(tbc_pkg::OFF_STATUS, 32'h0, "flag cleared after service");
		summarize();
	end
	initial
	begin
		repeat (20000) @(posedge CLK);
		errors++;
		$display("[FAIL] %0t watchdog expired", $time);
		summarize();
	end
endmodule
